// file: common/cid_pkg.sv
package cid_pkg;
	localparam int CID_LINES = 12;
	localparam int CID_AW    = 8;

	localparam logic [7:0] CID_REG_PULSE      = 8'h00;
	localparam logic [7:0] CID_REG_PULSE_SET  = 8'h10;
	localparam logic [7:0] CID_REG_PULSE_CLR  = 8'h20;
	localparam logic [7:0] CID_REG_ARM        = 8'h30;
	localparam logic [7:0] CID_REG_ENABLE     = 8'h34;
	localparam logic [7:0] CID_REG_REQUEST    = 8'h38;
	localparam logic [7:0] CID_REG_STATUS     = 8'h3C;
	localparam logic [7:0] CID_REG_MASK       = 8'h40;
	localparam logic [7:0] CID_REG_PIN_DIR    = 8'h44;
	localparam logic [7:0] CID_REG_PIN_TERM   = 8'h48;
	localparam logic [7:0] CID_REG_CLKSEL     = 8'h4C;
	localparam logic [7:0] CID_REG_ERROR      = 8'h50;
	localparam logic [7:0] CID_REG_PIN_ROUTE  = 8'h54;
	localparam logic [7:0] CID_REG_LINE_CFG   = 8'h80;
	localparam logic [7:0] CID_REG_LINE_CNT   = 8'hC0;
	localparam logic [7:0] CID_REG_LINE_MASK  = 8'hC0;
	localparam logic [7:0] CID_REG_IDX_MASK   = 8'h3C;

	// source select codes in line configuration bits [3:0]
	localparam logic [3:0] CID_SRC_NONE  = 4'h0;
	localparam logic [3:0] CID_SRC_TIMER = 4'h1;
	localparam logic [3:0] CID_SRC_PULSE = 4'h2;
	localparam logic [3:0] CID_SRC_EDGE  = 4'h3;
	localparam logic [3:0] CID_SRC_GPS   = 4'h4;
	localparam logic [3:0] CID_SRC_IRIG  = 4'h5;
	localparam int CID_CFG_SRC_LSB  = 0;
	localparam int CID_CFG_IDX_LSB  = 4;
	localparam int CID_CFG_TRIG_LSB = 8;

	typedef enum logic [1:0] {
		CID_TRIG_RISE = 2'h0,
		CID_TRIG_FALL = 2'h1,
		CID_TRIG_HIGH = 2'h2,
		CID_TRIG_LOW  = 2'h3
	} cid_trig_t;

	localparam logic [11:0] CID_PIN_DIR_RESET  = 12'h03F;
	localparam logic [11:0] CID_PIN_TERM_RESET = 12'h000;
	localparam logic [3:0]  CID_ROUTE_NONE     = 4'hF;

	localparam logic [1:0] CID_ERR_INVAL   = 2'h1;
	localparam logic [1:0] CID_ERR_SLAVE   = 2'h2;

	localparam int CID_REF_HZ = 10_000_000;
	localparam int CID_CNT_W  = 16;
endpackage

// file: rtl/cid_line.sv
`timescale 1ns/1ps
module cid_line
	import cid_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [1:0] trig,
	input  wire logic       level,
	input  wire logic       sw_request,
	output logic            fire
);
	logic last;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			last <= 1'b0;
		end else begin
			last <= level;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fire <= 1'b0;
		end else begin
			case (cid_trig_t'(trig))
				CID_TRIG_RISE: fire <= (level & ~last) | sw_request;
				CID_TRIG_FALL: fire <= (~level & last) | sw_request;
				CID_TRIG_HIGH: fire <= level | sw_request;
				default:       fire <= ~level | sw_request;
			endcase
		end
	end
endmodule

// file: rtl/cid_top.sv
`timescale 1ns/1ps
module cid_top
	import cid_pkg::*;
#(
	parameter int LINES = CID_LINES
) (
	input  wire logic               MCLK,
	input  wire logic               RST,
	input  wire logic [CID_AW-1:0]  ADDR,
	input  wire logic [31:0]        WDATA,
	input  wire logic               WR,
	input  wire logic               RD,
	output logic [31:0]             RDATA,
	input  wire logic [LINES-1:0]   TIMER_EVT,
	input  wire logic [LINES-1:0]   EDGE_IN,
	input  wire logic               GPS_PPS,
	input  wire logic               IRIG_PPS,
	input  wire logic [LINES-1:0]   CHAIN_IRQ_IN,
	output logic [LINES-1:0]        CHAIN_IRQ_OUT,
	output logic [LINES-1:0]        CHAIN_IRQ_OE,
	input  wire logic [LINES-1:0]   PIN_IN,
	output logic [LINES-1:0]        PIN_OUT,
	output logic [LINES-1:0]        PIN_OE,
	output logic [LINES-1:0]        PIN_TERM,
	input  wire logic               DEDICATED_REF_CLOCK_PIN,
	output logic                    REF_CLK_SEL,
	output logic                    REF_CLK_OUT,
	input  wire logic               CHAIN_SLAVE,
	output logic                    GPS_TIME_EN,
	output logic                    IRQ
);
	// line fields and index decode are sized for twelve lines at most
	if (LINES < 1 || LINES > CID_LINES) begin : gen_bad_lines
		$error("LINES must be 1..12");
	end

	logic [LINES-1:0] pulse_gen;
	logic [LINES-1:0] armed;
	logic [LINES-1:0] enabled;
	logic [LINES-1:0] sw_req;
	logic [LINES-1:0] status;
	logic [LINES-1:0] mask;
	logic [LINES-1:0] pin_dir;
	logic [LINES-1:0] line_fire;
	logic [1:0]       err;
	logic             clk_ext;
	logic             clk_use_pin;
	logic [3:0]       clk_pin;
	logic [3:0]       route [LINES];
	logic [3:0]       src   [LINES];
	logic [3:0]       sidx  [LINES];
	logic [1:0]       trig  [LINES];
	logic [CID_CNT_W-1:0] count [LINES];
	logic [LINES-1:0] drive_val;
	logic [LINES-1:0] next_pin_out;
	logic             next_ref;

	function automatic logic is_reg(input logic [CID_AW-1:0] a,
			input logic [CID_AW-1:0] base);
		is_reg = (a == base);
	endfunction

	function automatic logic [3:0] reg_index(input logic [CID_AW-1:0] a);
		reg_index = 4'((a & CID_REG_IDX_MASK) >> 2);
	endfunction

	function automatic logic pick(input logic [LINES-1:0] v,
			input logic [3:0] i);
		pick = (int'(i) < LINES) ? v[i] : 1'b0;
	endfunction

	wire wr_route = WR && is_reg(ADDR, CID_REG_PIN_ROUTE);
	wire [3:0] route_pin = WDATA[3:0];
	wire [3:0] route_src = WDATA[7:4];
	// a pin routed onto itself would form a loop through the pad
	wire route_bad = wr_route && (route_src == route_pin);

	wire wr_line_cfg = WR && (ADDR & CID_REG_LINE_MASK) == CID_REG_LINE_CFG;
	wire [3:0] wr_idx = reg_index(ADDR);

	// per-line source mux
	always_comb begin
		drive_val = '0;
		for (int i = 0; i < LINES; i++) begin
			case (src[i])
				CID_SRC_TIMER: drive_val[i] = pick(TIMER_EVT, sidx[i]);
				CID_SRC_PULSE: drive_val[i] = pick(pulse_gen, sidx[i]);
				CID_SRC_EDGE:  drive_val[i] = pick(EDGE_IN & ~pin_dir,
						sidx[i]);
				CID_SRC_GPS:   drive_val[i] = GPS_PPS;
				CID_SRC_IRIG:  drive_val[i] = IRIG_PPS;
				default:       drive_val[i] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			CHAIN_IRQ_OUT <= '0;
			CHAIN_IRQ_OE  <= '0;
		end else begin
			CHAIN_IRQ_OUT <= drive_val;
			for (int i = 0; i < LINES; i++) begin
				CHAIN_IRQ_OE[i] <= (src[i] != CID_SRC_NONE);
			end
		end
	end

	// line configuration: source, source index, trigger
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < LINES; i++) begin
				src[i]  <= CID_SRC_NONE;
				sidx[i] <= '0;
				trig[i] <= CID_TRIG_RISE;
			end
		end else if (wr_line_cfg && int'(wr_idx) < LINES) begin
			src[wr_idx]  <= WDATA[CID_CFG_SRC_LSB +: 4];
			sidx[wr_idx] <= WDATA[CID_CFG_IDX_LSB +: 4];
			trig[wr_idx] <= WDATA[CID_CFG_TRIG_LSB +: 2];
		end
	end

	genvar g;
	generate
		for (g = 0; g < LINES; g++) begin : gen_line
			cid_line u_line (
				.clk        (MCLK),
				.rst        (RST),
				.trig       (trig[g]),
				.level      (CHAIN_IRQ_IN[g]),
				.sw_request (sw_req[g]),
				.fire       (line_fire[g])
			);
		end
	endgenerate

	// pulse generators with atomic set and clear
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			pulse_gen <= '0;
		end else if (WR && is_reg(ADDR, CID_REG_PULSE)) begin
			pulse_gen <= WDATA[LINES-1:0];
		end else if (WR && is_reg(ADDR, CID_REG_PULSE_SET)) begin
			pulse_gen <= pulse_gen | WDATA[LINES-1:0];
		end else if (WR && is_reg(ADDR, CID_REG_PULSE_CLR)) begin
			pulse_gen <= pulse_gen & ~WDATA[LINES-1:0];
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			armed   <= '0;
			enabled <= '0;
			mask    <= '0;
		end else begin
			if (WR && is_reg(ADDR, CID_REG_ARM)) begin
				armed <= WDATA[LINES-1:0];
			end
			if (WR && is_reg(ADDR, CID_REG_ENABLE)) begin
				enabled <= WDATA[LINES-1:0];
			end
			if (WR && is_reg(ADDR, CID_REG_MASK)) begin
				mask <= WDATA[LINES-1:0];
			end
		end
	end

	// software request is a one-cycle pulse per written bit
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			sw_req <= '0;
		end else if (WR && is_reg(ADDR, CID_REG_REQUEST)) begin
			sw_req <= WDATA[LINES-1:0];
		end else begin
			sw_req <= '0;
		end
	end

	// sticky status; a new fire beats the clear-on-read
	wire rd_status = RD && is_reg(ADDR, CID_REG_STATUS);
	wire [LINES-1:0] report = line_fire & armed & enabled;
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			status <= '0;
		end else begin
			status <= (rd_status ? '0 : status) | report;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(((rd_status ? '0 : status) | report) & mask);
		end
	end

	// fire counts wrap; software reads the difference
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < LINES; i++) begin
				count[i] <= '0;
			end
		end else begin
			for (int i = 0; i < LINES; i++) begin
				if (report[i]) begin
					count[i] <= count[i] + CID_CNT_W'(1);
				end
			end
		end
	end

	// pin direction, termination and routing
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			pin_dir  <= CID_PIN_DIR_RESET;
			PIN_TERM <= CID_PIN_TERM_RESET;
		end else begin
			if (WR && is_reg(ADDR, CID_REG_PIN_DIR)) begin
				pin_dir <= WDATA[LINES-1:0];
			end
			if (WR && is_reg(ADDR, CID_REG_PIN_TERM)) begin
				PIN_TERM <= WDATA[LINES-1:0];
			end
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < LINES; i++) begin
				route[i] <= CID_ROUTE_NONE;
			end
		end else if (wr_route && !route_bad && int'(route_pin) < LINES) begin
			route[route_pin] <= route_src;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			err <= '0;
		end else if (route_bad) begin
			err <= CID_ERR_INVAL;
		end else if (CHAIN_SLAVE && WR && is_reg(ADDR, CID_REG_CLKSEL)
				&& WDATA[2]) begin
			err <= CID_ERR_SLAVE;
		end else if (RD && is_reg(ADDR, CID_REG_ERROR)) begin
			err <= '0;
		end
	end

	always_comb begin
		for (int i = 0; i < LINES; i++) begin
			next_pin_out[i] = (route[i] == CID_ROUTE_NONE) ? 1'b0 :
					pick(PIN_IN & ~pin_dir, route[i]);
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			PIN_OUT <= '0;
			PIN_OE  <= CID_PIN_DIR_RESET;
		end else begin
			PIN_OUT <= next_pin_out & pin_dir;
			PIN_OE  <= pin_dir;
		end
	end

	// clock select: bit0 external, bit1 use pin, bit2 gps, [7:4] pin
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			clk_ext     <= 1'b0;
			clk_use_pin <= 1'b0;
			clk_pin     <= '0;
			GPS_TIME_EN <= 1'b0;
		end else begin
			if (WR && is_reg(ADDR, CID_REG_CLKSEL)) begin
				clk_ext     <= WDATA[0];
				clk_use_pin <= WDATA[1];
				clk_pin     <= WDATA[7:4];
				GPS_TIME_EN <= WDATA[2] && !CHAIN_SLAVE;
			end else if (CHAIN_SLAVE) begin
				GPS_TIME_EN <= 1'b0;
			end
		end
	end

	always_comb begin
		if (clk_use_pin) begin
			next_ref = pick(PIN_IN & ~pin_dir, clk_pin);
		end else begin
			next_ref = DEDICATED_REF_CLOCK_PIN;
		end
	end

	// reference is sampled; the time base downstream picks it by select
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			REF_CLK_SEL <= 1'b0;
			REF_CLK_OUT <= 1'b0;
		end else begin
			REF_CLK_SEL <= clk_ext;
			REF_CLK_OUT <= clk_ext & next_ref;
		end
	end

	// read port, data valid the cycle after RD
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			RDATA <= '0;
		end else if (RD) begin
			RDATA <= '0;
			if ((ADDR & CID_REG_LINE_MASK) == CID_REG_LINE_CFG) begin
				if (int'(wr_idx) < LINES) begin
					RDATA[3:0]  <= src[wr_idx];
					RDATA[7:4]  <= sidx[wr_idx];
					RDATA[9:8]  <= trig[wr_idx];
				end
			end else if ((ADDR & CID_REG_LINE_MASK) == CID_REG_LINE_CNT) begin
				if (int'(wr_idx) < LINES) begin
					RDATA[CID_CNT_W-1:0] <= count[wr_idx];
				end
			end else if (is_reg(ADDR, CID_REG_PULSE)) begin
				RDATA[LINES-1:0] <= pulse_gen;
			end else if (is_reg(ADDR, CID_REG_ARM)) begin
				RDATA[LINES-1:0] <= armed;
			end else if (is_reg(ADDR, CID_REG_ENABLE)) begin
				RDATA[LINES-1:0] <= enabled;
			end else if (is_reg(ADDR, CID_REG_STATUS)) begin
				RDATA[LINES-1:0] <= status;
			end else if (is_reg(ADDR, CID_REG_MASK)) begin
				RDATA[LINES-1:0] <= mask;
			end else if (is_reg(ADDR, CID_REG_PIN_DIR)) begin
				RDATA[LINES-1:0] <= pin_dir;
			end else if (is_reg(ADDR, CID_REG_PIN_TERM)) begin
				RDATA[LINES-1:0] <= PIN_TERM;
			end else if (is_reg(ADDR, CID_REG_CLKSEL)) begin
				RDATA[7:0] <= {clk_pin, 1'b0, GPS_TIME_EN, clk_use_pin,
						clk_ext};
			end else if (is_reg(ADDR, CID_REG_ERROR)) begin
				RDATA[1:0] <= err;
			end else if (is_reg(ADDR, CID_REG_PIN_ROUTE)) begin
				RDATA[LINES-1:0] <= CHAIN_IRQ_IN;
			end
		end else begin
			RDATA <= '0;
		end
	end
endmodule

// file: sim/cid_chk.sv
`timescale 1ns/1ps
module cid_chk
	import cid_pkg::*;
#(
	parameter int LINES = CID_LINES
) (
	input wire logic             MCLK,
	input wire logic             RST,
	input wire logic             WR,
	input wire logic             RD,
	input wire logic [31:0]      RDATA,
	input wire logic             DEDICATED_REF_CLOCK_PIN,
	input wire logic             REF_CLK_SEL,
	input wire logic             REF_CLK_OUT,
	input wire logic             CHAIN_SLAVE,
	input wire logic             GPS_TIME_EN,
	input wire logic             IRQ,
	input wire logic [LINES-1:0] PIN_OE,
	input wire logic [LINES-1:0] PIN_TERM,
	input wire logic [LINES-1:0] CHAIN_IRQ_OE
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 32'h0)
		else $error("read data not zero outside a read");
	AST_RST_VALS: assert property ($fell(RST) |->
		PIN_OE == CID_PIN_DIR_RESET && PIN_TERM == '0
		&& CHAIN_IRQ_OE == '0)
		else $error("wrong values after reset");
	AST_PIN_HOLD: assert property (!$past(WR) && !$past(WR, 2) |->
		$stable(PIN_OE) && $stable(PIN_TERM))
		else $error("pin setting changed without a write");
	AST_OE_HOLD: assert property (!$past(WR) && !$past(WR, 2) |->
		$stable(CHAIN_IRQ_OE) && $stable(REF_CLK_SEL))
		else $error("line drive changed without a write");
	AST_REF_OFF: assert property (!REF_CLK_SEL && !$past(REF_CLK_SEL)
		|-> !REF_CLK_OUT)
		else $error("reference passed while not selected");
	AST_REF_FOLLOW: assert property (REF_CLK_SEL && $past(REF_CLK_SEL)
		|-> REF_CLK_OUT == $past(DEDICATED_REF_CLOCK_PIN))
		else $error("reference does not follow its pin");
	AST_SLAVE_NO_GPS: assert property (CHAIN_SLAVE && $past(CHAIN_SLAVE)
		|-> !GPS_TIME_EN)
		else $error("gps time enabled on a chain slave");
	AST_GPS_WR: assert property ($rose(GPS_TIME_EN) |-> $past(WR))
		else $error("gps time enabled without a write");
	AST_IRQ_FALL: assert property ($fell(IRQ) |-> $past(RD)
		|| $past(RD, 2) || $past(WR) || $past(WR, 2))
		else $error("interrupt dropped without an access");
	cover property ($rose(IRQ));
	cover property ($fell(IRQ));
	cover property ($rose(REF_CLK_SEL));
endmodule
bind cid_top cid_chk #(.LINES(LINES)) u_chk (.MCLK(MCLK), .RST(RST),
	.WR(WR), .RD(RD), .RDATA(RDATA), .REF_CLK_SEL(REF_CLK_SEL),
	.DEDICATED_REF_CLOCK_PIN(DEDICATED_REF_CLOCK_PIN),
	.REF_CLK_OUT(REF_CLK_OUT), .CHAIN_SLAVE(CHAIN_SLAVE),
	.GPS_TIME_EN(GPS_TIME_EN), .IRQ(IRQ), .PIN_OE(PIN_OE),
	.PIN_TERM(PIN_TERM), .CHAIN_IRQ_OE(CHAIN_IRQ_OE));

// file: sim/cid_chain_peer.sv
`timescale 1ns/1ps
module cid_chain_peer (
	input  wire logic [11:0] dut_out,
	input  wire logic [11:0] dut_oe,
	input  wire logic [11:0] peer_oe,
	input  wire logic [11:0] peer_val,
	output logic      [11:0] line_lvl
);
	// an undriven line is pulled low, never left at the last value
	always_comb begin
		for (int i = 0; i < 12; i++) begin
			if (dut_oe[i])
				line_lvl[i] = dut_out[i];
			else if (peer_oe[i])
				line_lvl[i] = peer_val[i];
			else
				line_lvl[i] = 1'b0;
		end
	end
endmodule

// file: sim/tb.sv
`timescale 1ns/1ps
module tb
	import cid_pkg::*;
;
	logic        mclk, rst, wr_stb, rd_stb, gps, irig, ref_pin, slave;
	logic        ref_sel, ref_out, gps_en, irq;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, rnd, d, r;
	logic [11:0] timer, edge_in, pin_in, peer_oe, peer_val, chain_in;
	logic [11:0] irq_out, irq_oe, pin_out, pin_oe, pin_term;
	int          num_errors, checks_done;
	int          exp_cnt[12] = '{default: 0};

	always #25 mclk = ~mclk;
	cid_chain_peer u_peer (.dut_out(irq_out), .dut_oe(irq_oe),
		.peer_oe(peer_oe), .peer_val(peer_val), .line_lvl(chain_in));
	cid_top u_dut (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata),
		.WR(wr_stb), .RD(rd_stb), .RDATA(rdata), .TIMER_EVT(timer),
		.EDGE_IN(edge_in), .GPS_PPS(gps), .IRIG_PPS(irig),
		.CHAIN_IRQ_IN(chain_in), .CHAIN_IRQ_OUT(irq_out),
		.CHAIN_IRQ_OE(irq_oe), .PIN_IN(pin_in), .PIN_OUT(pin_out),
		.PIN_OE(pin_oe), .PIN_TERM(pin_term), .REF_CLK_SEL(ref_sel),
		.DEDICATED_REF_CLOCK_PIN(ref_pin), .REF_CLK_OUT(ref_out),
		.CHAIN_SLAVE(slave), .GPS_TIME_EN(gps_en), .IRQ(irq));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	always @(posedge mclk) begin
		rnd <= lfsr(rnd);
		pin_in <= rnd[11:0];
		ref_pin <= rnd[12];
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		@(negedge mclk);
		chk(nm, e, rdata);
	endtask
	task automatic pulse(input int n, input logic act);
		@(posedge mclk);
		peer_val[n] <= act;
		repeat (5) @(posedge mclk);
		peer_val[n] <= ~act;
		repeat (4) @(posedge mclk);
	endtask
	task automatic cnt(input int n);
		rdc("count", 8'(CID_REG_LINE_CNT + 4 * n), exp_cnt[n] & 32'hFFFF);
	endtask
	task automatic src(input int s, input logic v);
		if (s == 2)
			wr(v ? CID_REG_PULSE_SET : CID_REG_PULSE_CLR, 32'h80);
		else begin
			@(posedge mclk);
			case (s)
				1: timer[7] <= v;
				3: edge_in[7] <= v;
				4: gps <= v;
				default: irig <= v;
			endcase
		end
		repeat (3) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic results;
		if (num_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		results;
	end
	initial begin
		{mclk, wr_stb, rd_stb, gps, irig, ref_pin, slave} = '0;
		{addr, wdata, timer, edge_in, pin_in, peer_val} = '0;
		rst = 1'b1;
		peer_oe = 12'h01F;
		rnd = 32'hA80E;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		chk("pin_oe", 32'h03F, pin_oe);
		chk("pin_term", 32'h0, pin_term);
		chk("line_oe", 32'h0, irq_oe);
		rdc("unmapped", 8'h60, 32'h0);
		wr(CID_REG_MASK, 32'h01F);
		pulse(4, 1'b1);
		cnt(4);
		wr(CID_REG_ARM, 32'hFFF);
		pulse(4, 1'b1);
		cnt(4);
		wr(CID_REG_ENABLE, 32'hFFF);
		pulse(4, 1'b1);
		exp_cnt[4]++;
		cnt(4);
		chk("irq", 32'h1, irq);
		rdc("status", CID_REG_STATUS, 32'h010);
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk("irq", 32'h0, irq);
		wr(CID_REG_REQUEST, 32'h010);
		exp_cnt[4]++;
		repeat (3) @(posedge mclk);
		cnt(4);
		rdc("status", CID_REG_STATUS, 32'h010);
		for (int t = 0; t < 4; t++) begin
			// idle high lines rise once while still on the reset trigger
			@(posedge mclk);
			peer_val[t] <= t[0];
			exp_cnt[t] += t[0];
			repeat (4) @(posedge mclk);
			wr(8'(CID_REG_LINE_CFG + 4 * t), t << CID_CFG_TRIG_LSB);
			pulse(t, ~t[0]);
			exp_cnt[t] += (t < 2) ? 1 : 5;
			cnt(t);
			rdc("status", CID_REG_STATUS, 32'h1 << t);
		end
		for (int s = 1; s < 6; s++) begin
			// source index 7 is an input pin after reset
			wr(8'h94, s | 32'h70);
			src(s, 1'b1);
			chk("line_oe", 32'h1, irq_oe[5]);
			chk("line_out", 32'h1, irq_out[5]);
			src(s, 1'b0);
			chk("line_out", 32'h0, irq_out[5]);
		end
		wr(8'h94, 32'h53);
		@(posedge mclk);
		edge_in[5] <= 1'b1;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		chk("line_out", 32'h0, irq_out[5]);
		@(posedge mclk);
		edge_in[5] <= 1'b0;
		wr(8'h94, 32'h0);
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk("line_oe", 32'h0, irq_oe);
		wr(CID_REG_PULSE_SET, 32'h801);
		wr(CID_REG_PULSE_CLR, 32'h001);
		rdc("pulse", CID_REG_PULSE, 32'h800);
		wr(CID_REG_PULSE_CLR, 32'hFFF);
		r = rnd;
		wr(CID_REG_PIN_DIR, r[11:0]);
		wr(CID_REG_PIN_TERM, ~r[11:0]);
		@(negedge mclk);
		chk("pin_oe", r[11:0], pin_oe);
		chk("pin_term", {20'h0, ~r[11:0]}, pin_term);
		wr(CID_REG_PIN_ROUTE, 32'h33);
		rdc("error", CID_REG_ERROR, CID_ERR_INVAL);
		wr(CID_REG_PIN_DIR, 32'h03F);
		wr(CID_REG_PIN_ROUTE, 32'h72);
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		d[0] = pin_in[7];
		@(negedge mclk);
		chk("pin_out", d[0], pin_out[2]);
		chk("pin_out", 32'h0, pin_out[3]);
		wr(CID_REG_CLKSEL, 32'h1);
		@(posedge mclk);
		@(negedge mclk);
		chk("ref_sel", 32'h1, ref_sel);
		repeat (20) @(posedge mclk);
		slave <= 1'b1;
		wr(CID_REG_CLKSEL, 32'h5);
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk("gps_en", 32'h0, gps_en);
		rdc("error", CID_REG_ERROR, CID_ERR_SLAVE);
		wr(CID_REG_CLKSEL, 32'h1);
		slave <= 1'b0;
		wr(CID_REG_CLKSEL, 32'h4);
		@(negedge mclk);
		chk("gps_en", 32'h1, gps_en);
		results;
	end
endmodule
